/* design/svis_core_end.sv */
// Core end: global enable, acknowledge and the interrupt machine cycle.
//
// The implementer's own choice: the plain strobed port.
`include "svis_defs.svh"
module svis_core_end
  import svis_pkg::*;
(
  // Link.
  svis_if.core_end  lnk,
  // Core state to be saved.
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_flags,
  // Software port.
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic      [7:0]  o_rdata,
  // Results.
  output logic      [15:0] o_branch_addr,
  output logic             o_branch,
  output logic             o_busy,
  output logic             o_irq
);
  svis_state_t state_reg, state_next;
  logic [7:0]  ctrl_reg;
  logic [15:0] pc_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  vec_hi_reg;
  logic [15:0] branch_reg;
  logic        branch_reg_q;
  logic [`SVIS_NUM_EV-1:0] stat_reg, irq_en_reg, ev;
  logic        gie;
  logic        cmd_wr, take, ret, bound;
  logic        ctrl_wr;

  assign gie     = ctrl_reg[`SVIS_GIE_BIT];
  assign cmd_wr  = i_we && (i_addr == `SVIS_CMD_ADDR);
  assign ctrl_wr = i_we && (i_addr == `SVIS_CORE_CTRL_ADDR);
  assign bound   = cmd_wr && i_wdata[`SVIS_CMD_BOUND_BIT];
  assign ret     = cmd_wr && i_wdata[`SVIS_CMD_RET_BIT];
  // Taken only at an instruction boundary with both enables present.
  // A flag left pending while masked is taken at the next boundary.
  // Boundary strobes that land while busy are dropped on purpose, so
  // a second request cannot restart a machine cycle halfway through.
  assign take = bound && gie && lnk.irq
             && (state_reg == SVIS_IDLE);

  // ----------------------------------------------------------------------
  // Interrupt machine state.
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SVIS_IDLE:  state_next = take ? SVIS_CLR : SVIS_IDLE;
      SVIS_CLR:   state_next = SVIS_PUSHL;
      SVIS_PUSHL: state_next = SVIS_PUSHH;
      SVIS_PUSHH: state_next = SVIS_PUSHF;
      SVIS_PUSHF: state_next = SVIS_VECH;
      SVIS_VECH:  state_next = SVIS_VECL;
      SVIS_VECL:  state_next = SVIS_RETN;
      SVIS_RETN:  state_next = SVIS_IDLE;
      default:    state_next = SVIS_IDLE;
    endcase
  end

  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      state_reg <= SVIS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Acknowledge precedes any push or fetch of the routine address.
  assign lnk.ack = take;
  assign o_busy  = (state_reg != SVIS_IDLE);

  // ----------------------------------------------------------------------
  // Global enable. Reset leaves it clear; software must enable it.
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      ctrl_reg <= `SVIS_CORE_CTRL_RST;
    end else if (take) begin
      ctrl_reg[`SVIS_GIE_BIT] <= 1'b0;
    end else if (ret) begin
      ctrl_reg[`SVIS_GIE_BIT] <= 1'b1;
    end else if (cmd_wr && i_wdata[`SVIS_CMD_EI_BIT]) begin
      ctrl_reg[`SVIS_GIE_BIT] <= 1'b1;
    end else if (cmd_wr && i_wdata[`SVIS_CMD_DI_BIT]) begin
      ctrl_reg[`SVIS_GIE_BIT] <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_reg <= i_wdata;
    end
  end

  // Capture the state to push at acknowledge; the core may move on.
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      pc_reg    <= 16'h0000;
      flags_reg <= 8'h00;
    end else if (take) begin
      pc_reg    <= i_pc;
      flags_reg <= i_flags;
    end
  end

  // ----------------------------------------------------------------------
  // Stack pushes and vector fetches.
  // ----------------------------------------------------------------------
  always_comb begin
    lnk.stack_we   = 1'b0;
    lnk.stack_data = 8'h00;
    lnk.mem_re     = 1'b0;
    lnk.mem_addr   = 16'h0000;
    case (state_reg)
      SVIS_PUSHL: begin
        lnk.stack_we   = 1'b1;
        lnk.stack_data = pc_reg[7:0];
      end
      SVIS_PUSHH: begin
        lnk.stack_we   = 1'b1;
        lnk.stack_data = pc_reg[15:8];
      end
      SVIS_PUSHF: begin
        lnk.stack_we   = 1'b1;
        lnk.stack_data = flags_reg;
        lnk.mem_re     = 1'b1;
        lnk.mem_addr   = `SVIS_VEC_HI_ADDR;
      end
      SVIS_VECH: begin
        lnk.mem_re     = 1'b1;
        lnk.mem_addr   = `SVIS_VEC_LO_ADDR;
      end
      default: begin
        lnk.mem_re     = 1'b0;
      end
    endcase
  end

  // Vector bytes arrive one cycle after each fetch strobe.
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      vec_hi_reg   <= 8'h00;
      branch_reg   <= 16'h0000;
      branch_reg_q <= 1'b0;
    end else begin
      branch_reg_q <= (state_reg == SVIS_VECL);
      if (state_reg == SVIS_VECH) begin
        vec_hi_reg <= lnk.mem_data;
      end
      if (state_reg == SVIS_VECL) begin
        branch_reg <= {vec_hi_reg, lnk.mem_data};
      end
    end
  end
  assign o_branch_addr = branch_reg;
  assign o_branch      = branch_reg_q;

  // ----------------------------------------------------------------------
  // Event status, enable and level interrupt.
  // ----------------------------------------------------------------------
  assign ev = {ret, branch_reg_q, take};

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      stat_reg <= '0;
    end else begin
      for (int k = 0; k < `SVIS_NUM_EV; k++) begin
        if (ev[k]) begin
          stat_reg[k] <= 1'b1;
        end else if (i_we && i_addr == `SVIS_IRQ_CLR_ADDR && i_wdata[k]) begin
          stat_reg[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      irq_en_reg <= '0;
    end else if (i_we && i_addr == `SVIS_IRQ_EN_ADDR) begin
      irq_en_reg <= i_wdata[`SVIS_NUM_EV-1:0];
    end
  end
  assign o_irq = |(stat_reg & irq_en_reg);

  // Read data one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_re) begin
      case (i_addr)
        `SVIS_CORE_CTRL_ADDR: o_rdata <= ctrl_reg;
        `SVIS_STATUS_ADDR:    o_rdata <= {5'h00, stat_reg};
        `SVIS_IRQ_EN_ADDR:    o_rdata <= {5'h00, irq_en_reg};
        `SVIS_PC_LO_ADDR:     o_rdata <= pc_reg[7:0];
        `SVIS_PC_HI_ADDR:     o_rdata <= pc_reg[15:8];
        `SVIS_FLAGS_ADDR:     o_rdata <= flags_reg;
        default:              o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : svis_core_end

/* design/svis_defs.svh */
// Constants of the single-vector interrupt sequencer.
`ifndef SVIS_DEFS_SVH
`define SVIS_DEFS_SVH
// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SVIS_CORE_CTRL_ADDR   8'hDF
`define SVIS_GIE_BIT          3
`define SVIS_CORE_CTRL_RST    8'h00
`define SVIS_PEND_ADDR        8'hE0
`define SVIS_SRC_EN_ADDR      8'hE1
`define SVIS_STATUS_ADDR      8'hE2
`define SVIS_IRQ_EN_ADDR      8'hE3
`define SVIS_IRQ_CLR_ADDR     8'hE4
`define SVIS_PC_LO_ADDR       8'hE5
`define SVIS_PC_HI_ADDR       8'hE6
`define SVIS_FLAGS_ADDR       8'hE7
`define SVIS_CMD_ADDR         8'hE8
`define SVIS_PEND_RST         8'h00
`define SVIS_SRC_EN_RST       8'h00
// ----------------------------------------------------------------------
// Vector and source layout
// ----------------------------------------------------------------------
`define SVIS_VEC_HI_ADDR      16'h0000
`define SVIS_VEC_LO_ADDR      16'h0001
`define SVIS_NUM_SRC          8
// Command register bits (core side).
`define SVIS_CMD_EI_BIT       0
`define SVIS_CMD_DI_BIT       1
`define SVIS_CMD_RET_BIT      2
`define SVIS_CMD_BOUND_BIT    3
// Status bits of the event interrupt.
`define SVIS_EV_ACK_BIT       0
`define SVIS_EV_DONE_BIT      1
`define SVIS_EV_RET_BIT       2
`define SVIS_NUM_EV           3
`endif

/* design/svis_if.sv */
// Link between peripheral sources and the core interrupt sequencer.
interface svis_if (
  input wire logic i_clk,
  input wire logic i_rst_n
);
  logic [7:0] set_pend;  // One-cycle pulses, one per source.
  logic [7:0] pend;      // Pending flags held by the source end.
  logic [7:0] src_en;    // Per-source enables.
  logic       irq;       // Combined request toward the core.
  logic       ack;       // Acknowledge pulse from the core.
  logic       stack_we;  // Stack push strobe.
  logic [7:0] stack_data;
  logic       mem_re;    // Vector fetch strobe.
  logic [15:0] mem_addr;
  logic [7:0] mem_data;  // Vector byte, valid the cycle after mem_re.

  modport src_end (
    input  i_clk, i_rst_n, set_pend, ack,
    output pend, src_en, irq
  );
  modport core_end (
    input  i_clk, i_rst_n, irq, mem_data,
    output ack, stack_we, stack_data, mem_re, mem_addr
  );
endinterface : svis_if

/* design/svis_pend_bit.sv */
// One pending flag with software clear by written zero.
module svis_pend_bit (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Control.
  input  wire logic i_set,
  input  wire logic i_wr,
  input  wire logic i_wr_bit,
  // Flag.
  output logic      o_pend
);
  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pend <= 1'b0;
    end else if (i_set) begin
      o_pend <= 1'b1;
    end else if (i_wr && !i_wr_bit) begin
      o_pend <= 1'b0;
    end
  end
endmodule : svis_pend_bit

/* design/svis_pkg.sv */
// Types shared by both ends of the interrupt sequencer.
package svis_pkg;
  // Interrupt machine states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    SVIS_IDLE  = 3'h0,
    SVIS_CLR   = 3'h1,
    SVIS_PUSHL = 3'h3,
    SVIS_PUSHH = 3'h2,
    SVIS_PUSHF = 3'h6,
    SVIS_VECH  = 3'h7,
    SVIS_VECL  = 3'h5,
    SVIS_RETN  = 3'h4
  } svis_state_t;
endpackage : svis_pkg

/* design/svis_src_end.sv */
// Source end: pending flags, source enables and the combined request.
`include "svis_defs.svh"
module svis_src_end
  import svis_pkg::*;
(
  // Link.
  svis_if.src_end   lnk,
  // Software port.
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_we,
  input  wire logic       i_re,
  output logic      [7:0] o_rdata
);
  logic [7:0] src_en_reg;
  logic       wr_pend;

  assign wr_pend = i_we && (i_addr == `SVIS_PEND_ADDR);

  // ----------------------------------------------------------------------
  // Pending flags, one per source: timers, port pins, watch timer, UART.
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SVIS_NUM_SRC; g++) begin : g_pend
      svis_pend_bit u_bit (
        .i_clk    (lnk.i_clk),
        .i_rst_n  (lnk.i_rst_n),
        .i_set    (lnk.set_pend[g]),
        .i_wr     (wr_pend),
        .i_wr_bit (i_wdata[g]),
        .o_pend   (lnk.pend[g])
      );
    end
  endgenerate

  // Source enable register.
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      src_en_reg <= `SVIS_SRC_EN_RST;
    end else if (i_we && i_addr == `SVIS_SRC_EN_ADDR) begin
      src_en_reg <= i_wdata;
    end
  end
  assign lnk.src_en = src_en_reg;

  // No priority logic: any enabled flag raises the one request line.
  assign lnk.irq = |(lnk.pend & src_en_reg);

  // Read data one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge lnk.i_clk) begin
    if (!lnk.i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_re) begin
      case (i_addr)
        `SVIS_PEND_ADDR:   o_rdata <= lnk.pend;
        `SVIS_SRC_EN_ADDR: o_rdata <= src_en_reg;
        default:           o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : svis_src_end

/* tb/single_vector_interrupt_sequencer_tb_top.sv */
// Self-checking bench for both ends of the interrupt sequencer.
module single_vector_interrupt_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // Signals and instances
  // --------------------
  logic        i_clk;
  logic        i_rst_n;
  logic [7:0]  addr, wdata, sp, s_rd, c_rd, flags;
  logic [7:0]  md = 8'h00;
  logic        we, re, br, busy, c_irq;
  logic [15:0] pc, br_addr;
  int          failures, cmp_count;
  int          acks = 0;
  logic [7:0]  stk[$];
  svis_if lnk (.i_clk(i_clk), .i_rst_n(i_rst_n));
  assign lnk.set_pend = sp;
  assign lnk.mem_data = md;
  svis_src_end u_svis_src_end (.lnk(lnk), .i_addr(addr),
    .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(s_rd));
  svis_core_end u_svis_core_end (.lnk(lnk), .i_pc(pc),
    .i_flags(flags), .i_addr(addr), .i_wdata(wdata), .i_we(we),
    .i_re(re), .o_rdata(c_rd), .o_branch_addr(br_addr),
    .o_branch(br), .o_busy(busy), .o_irq(c_irq));
  svis_asserts u_svis_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .set_pend(lnk.set_pend), .pend(lnk.pend), .src_en(lnk.src_en),
    .irq(lnk.irq), .ack(lnk.ack), .stack_we(lnk.stack_we),
    .mem_re(lnk.mem_re), .mem_addr(lnk.mem_addr));
  // Free-running core clock.
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Vector memory answers a cycle late; idle cycles toggle so stale
  // data never looks valid. Pushes and acknowledges are recorded.
  always @(posedge i_clk) begin
    if (lnk.mem_re === 1'b1)
      md <= (lnk.mem_addr == 16'h0000) ? 8'h3C : 8'hA9;
    else
      md <= ~md;
    if (lnk.stack_we === 1'b1)
      stk.push_back(lnk.stack_data);
    if (lnk.ack === 1'b1)
      acks <= acks + 1;
  end
  // --------------------
  // Bus tasks
  // --------------------
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge i_clk);
    we <= 1'b0;
    // Return mid-cycle so the acknowledge count of the strobe is settled.
    @(negedge i_clk);
  endtask : wr
  // Read data stand one cycle only, so they are taken just after it opens.
  task automatic rc(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge i_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge i_clk);
    re <= 1'b0;
    #1;
    chk(nm, {16'h0000, exp}, {16'h0000, s_rd | c_rd});
  endtask : rc
  task automatic pulse(logic [7:0] v);
    @(posedge i_clk);
    sp <= v;
    @(posedge i_clk);
    sp <= 8'h00;
  endtask : pulse
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Bounded wait for the branch pulse; a hang closes the run.
  task automatic wait_br();
    int n;
    n = 0;
    while (br !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    if (br !== 1'b1) begin
      failures++;
      $display("CHECK FAILED branch exp 1 got 0");
      end_sim();
    end
  endtask : wait_br
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    rc("ctrl", 8'hDF, 8'h00);
    rc("pend", 8'hE0, 8'h00);
    rc("unmapped", 8'hF0, 8'h00);
    pulse(8'h01);
    wr(8'hE1, 8'h01);
    wr(8'hE8, 8'h08);
    chk("ack", 24'h0, 24'(acks));
    wr(8'hE0, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_pend();
    pulse(8'h24);
    rc("pend", 8'hE0, 8'h24);
    wr(8'hE0, 8'hFF);
    rc("pend", 8'hE0, 8'h24);
    wr(8'hE0, 8'hFB);
    rc("pend", 8'hE0, 8'h20);
    wr(8'hE0, 8'h00);
    $display("test pend done");
  endtask : t_pend
  task automatic t_src();
    pulse(8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(8'hE1, 8'h01 << i);
      @(negedge i_clk);
      chk("irq", 24'h1, {23'h0, lnk.irq});
    end
    wr(8'hE1, 8'h00);
    @(negedge i_clk);
    chk("irq", 24'h0, {23'h0, lnk.irq});
    wr(8'hE0, 8'h00);
    wr(8'hE1, 8'hFF);
    @(negedge i_clk);
    chk("irq", 24'h0, {23'h0, lnk.irq});
    $display("test sources done");
  endtask : t_src
  task automatic t_serve();
    @(posedge i_clk);
    pc <= 16'h1234;
    flags <= 8'hA5;
    wr(8'hE3, 8'h07);
    pulse(8'h10);
    wr(8'hE8, 8'h01);
    rc("ctrl", 8'hDF, 8'h08);
    wr(8'hE8, 8'h08);
    chk("busy", 24'h1, {23'h0, busy});
    wait_br();
    chk("ack", 24'h1, 24'(acks));
    chk("vector", 24'h3CA9, {8'h00, br_addr});
    chk("stack", 24'h3412A5, {stk[0], stk[1], stk[2]});
    rc("ctrl", 8'hDF, 8'h00);
    chk("busy", 24'h0, {23'h0, busy});
    rc("pc lo", 8'hE5, 8'h34);
    rc("pc hi", 8'hE6, 8'h12);
    rc("flags", 8'hE7, 8'hA5);
    rc("status", 8'hE2, 8'h03);
    chk("o_irq", 24'h1, {23'h0, c_irq});
    wr(8'hE4, 8'h07);
    rc("status", 8'hE2, 8'h00);
    chk("o_irq", 24'h0, {23'h0, c_irq});
    $display("test service done");
  endtask : t_serve
  task automatic t_ret();
    wr(8'hE8, 8'h08);
    chk("ack", 24'h1, 24'(acks));
    wr(8'hE8, 8'h04);
    rc("ctrl", 8'hDF, 8'h08);
    rc("status", 8'hE2, 8'h04);
    rc("pend", 8'hE0, 8'h10);
    wr(8'hE8, 8'h08);
    wait_br();
    chk("ack", 24'h2, 24'(acks));
    wr(8'hE0, 8'h00);
    wr(8'hE8, 8'h04);
    $display("test return done");
  endtask : t_ret
  task automatic t_mask();
    wr(8'hE8, 8'h02);
    rc("ctrl", 8'hDF, 8'h00);
    pulse(8'h01);
    wr(8'hE8, 8'h08);
    chk("ack", 24'h2, 24'(acks));
    wr(8'hDF, 8'h08);
    wr(8'hE8, 8'h08);
    wait_br();
    chk("ack", 24'h3, 24'(acks));
    wr(8'hE1, 8'hFE);
    wr(8'hE8, 8'h04);
    wr(8'hE8, 8'h08);
    chk("ack", 24'h3, 24'(acks));
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rc("pend", 8'hE0, 8'h00);
    rc("ctrl", 8'hDF, 8'h00);
    $display("test mask done");
  endtask : t_mask
  // Main sequence: everything starts defined, reset spans ten cycles.
  initial begin
    i_rst_n = 1'b0;
    {addr, wdata, sp, flags} = '0;
    {we, re} = 2'b00;
    pc = 16'h0000;
    {failures, cmp_count} = '0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_pend();
    t_src();
    t_serve();
    t_ret();
    t_mask();
    end_sim();
  end
endmodule : single_vector_interrupt_sequencer_tb_top

/* tb/svis_asserts.sv */
// Concurrent checks on the link between the two ends.
module svis_asserts (
  // Link signals.
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  set_pend,
  input wire logic [7:0]  pend,
  input wire logic [7:0]  src_en,
  input wire logic        irq,
  input wire logic        ack,
  input wire logic        stack_we,
  input wire logic        mem_re,
  input wire logic [15:0] mem_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // Properties
  // --------------------
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  irq_or_a: assert property (irq == |(pend & src_en))
    else $error("request is not the OR of enabled flags");
  pend_set_a: assert property ((set_pend != 8'h00) |=>
    ((pend & $past(set_pend)) == $past(set_pend)))
    else $error("set pulse did not raise its flag");
  pend_cause_a: assert property
    ((pend & ~$past(pend) & ~$past(set_pend)) == 8'h00)
    else $error("flag rose without a set pulse");
  ack_gate_a: assert property (ack |-> irq)
    else $error("acknowledge without an enabled request");
  push_seq_a: assert property
    (ack |=> !stack_we ##1 stack_we [*3] ##1 !stack_we)
    else $error("push burst is not three cycles after clear");
  vec_fetch_a: assert property (ack |-> ##4
    (mem_re && mem_addr == 16'h0000) ##1
    (mem_re && mem_addr == 16'h0001))
    else $error("vector fetch address or timing wrong");
  fetch_order_a: assert property (mem_re |-> $past(stack_we))
    else $error("vector fetch not preceded by a push");
  one_ack_a: assert property (ack |=> !ack [*7])
    else $error("second acknowledge inside machine cycle");
  ack_first_a: assert property ($rose(stack_we) |-> $past(ack, 2))
    else $error("push started without acknowledge");
endmodule : svis_asserts
